// ### design/pin_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser; first stage feeds only the second
module pin_sync (
  // Clock
  input wire logic clk,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);

  logic stage1_reg;
  logic stage2_reg;

  // No reset, so a pin held during system reset still reaches the capture logic
  always_ff @(posedge clk) begin
    stage1_reg <= async_in;
    stage2_reg <= stage1_reg;
  end

  assign sync_out = stage2_reg;

endmodule // pin_sync

// ### design/special_function_pkg.sv
// Function
// RL1: Registers decoded from fixed base, id first
// RL2: Identification low five bits hold version
// RL3: Program nonvolatile size uses listed codes only
// RL4: Nonvolatile data size reads none
// RL5: Volatile data size is one-hot or none
// RL6: Family code is two fixed BCD digits
// RL7: Program memory type is flash or other
// RL8: Extension flag reads zero
// RL9: Extension word is read-only and hardwired
// RL10: Reset cause reads external or watchdog code
// RL11: Protect write needs key in upper half
// RL12: Key field always reads back zero
// RL13: Protect bit drives interrupt controller mode
// RL14: Watchdog reset needs enable and overflow
// RL15: Fixed id bits; read-only registers ignore writes
// RL16: Protect resets normal; reserved offsets read zero
package special_function_pkg;

  localparam logic [31:0] BASE_ADDR = 32'hFFF00000;
  localparam logic [7:0] ID_OFFSET = 8'h00;
  localparam logic [7:0] EXTENSION_OFFSET = 8'h04;
  localparam logic [7:0] CAUSE_OFFSET = 8'h08;
  localparam logic [7:0] RESERVED_A_OFFSET = 8'h10;
  localparam logic [7:0] RESERVED_B_OFFSET = 8'h14;
  localparam logic [7:0] PROTECT_OFFSET = 8'h18;

  // Identification word field positions
  localparam int VERSION_LSB = 0;
  localparam int FIXED_LSB = 5;
  localparam int PROG_SIZE_LSB = 8;
  localparam int DATA_NV_SIZE_LSB = 12;
  localparam int VOLATILE_SIZE_LSB = 16;
  localparam int FAMILY_LSB = 20;
  localparam int MEM_TYPE_LSB = 28;
  localparam int EXT_FLAG_BIT = 31;
  localparam logic [2:0] FIXED_PATTERN = 3'h2;
  localparam logic [4:0] VERSION_MAX = 5'h1F;

  localparam logic [3:0] PROG_SIZE_NONE = 4'h0;
  localparam logic [3:0] PROG_SIZE_32K = 4'h3;
  localparam logic [3:0] PROG_SIZE_64K = 4'h5;
  localparam logic [3:0] PROG_SIZE_128K = 4'h7;
  localparam logic [3:0] PROG_SIZE_256K = 4'h8;
  localparam logic [3:0] DATA_NV_SIZE_NONE = 4'h0;
  localparam logic [2:0] MEM_TYPE_FLASH = 3'h1;
  localparam logic [2:0] MEM_TYPE_OTHER = 3'h4;

  localparam logic [7:0] CAUSE_EXTERNAL = 8'h6C;
  localparam logic [7:0] CAUSE_WATCHDOG = 8'h53;

  localparam logic [15:0] PROTECT_KEY = 16'h27A8;
  localparam int KEY_LSB = 16;
  localparam int PROTECT_BIT = 5;
  localparam logic PROTECT_RESET = 1'b0;

endpackage

// ### design/special_function_registers.sv
`timescale 1ns/100ps
module special_function_registers #(
  parameter logic [4:0] VERSION = 5'h00,
  parameter logic [3:0] PROG_SIZE = 4'h8,
  parameter logic [3:0] DATA_NV_SIZE = 4'h0,
  parameter logic [3:0] VOLATILE_SIZE = 4'h8,
  // Arbitrary neutral value
  parameter logic [7:0] FAMILY_CODE = 8'h12,
  parameter logic [2:0] MEM_TYPE = 3'h1,
  // Arbitrary neutral value
  parameter logic [31:0] EXTENSION_WORD = 32'h00000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources
  input wire logic external_reset_pin_b,
  input wire logic watchdog_overflow,
  input wire logic watchdog_reset_enable,
  output logic watchdog_internal_reset,
  // Interrupt controller mode
  output logic interrupt_ctrl_protect_enable
);

  // Legal encodings only
  initial begin
    if (VERSION > special_function_pkg::VERSION_MAX) begin // RL2
      $error("version out of range");
    end
    if (!(PROG_SIZE inside {special_function_pkg::PROG_SIZE_NONE, special_function_pkg::PROG_SIZE_32K,
        special_function_pkg::PROG_SIZE_64K, special_function_pkg::PROG_SIZE_128K,
        special_function_pkg::PROG_SIZE_256K})) begin // RL3
      $error("reserved program size code");
    end
    if (DATA_NV_SIZE != special_function_pkg::DATA_NV_SIZE_NONE) begin // RL4
      $error("reserved data nonvolatile size code");
    end
    if (!(VOLATILE_SIZE inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8})) begin // RL5
      $error("volatile size must be one-hot or none");
    end
    if (FAMILY_CODE[7:4] > 4'h9 || FAMILY_CODE[3:0] > 4'h9) begin // RL6
      $error("family code must be two BCD digits");
    end
    if (!(MEM_TYPE inside {special_function_pkg::MEM_TYPE_FLASH, special_function_pkg::MEM_TYPE_OTHER})) begin // RL7
      $error("reserved memory type code");
    end
    // Decode compares only the upper 24 address bits
    if (special_function_pkg::BASE_ADDR[7:0] != 8'h00) begin // RL1
      $error("base address must leave the low byte free");
    end
    if (special_function_pkg::PROTECT_BIT >= special_function_pkg::KEY_LSB) begin // RL12
      $error("protect bit must sit below the key field");
    end
  end

  // Hardwired identification word
  localparam logic [31:0] ID_WORD = {1'b0, // RL8
    MEM_TYPE, // RL7
    FAMILY_CODE, // RL6
    VOLATILE_SIZE, // RL5
    DATA_NV_SIZE, // RL4
    PROG_SIZE, // RL3
    special_function_pkg::FIXED_PATTERN, // RL15
    VERSION}; // RL2

  // Pin synchroniser
  logic ext_pin_sync;
  logic ext_pin_low;

  pin_sync ext_pin_sync_u (
    .clk(clk),
    .async_in(external_reset_pin_b),
    .sync_out(ext_pin_sync)
  );

  assign ext_pin_low = !ext_pin_sync;

  // Address decode
  logic in_window;
  logic [7:0] offset;
  logic hit_id;
  logic hit_ext;
  logic hit_cause;
  logic hit_reserved;
  logic hit_protect;
  logic mapped;
  logic setup_phase;
  logic access_phase;
  logic key_ok;
  logic protect_write;

  assign in_window = paddr[31:8] == special_function_pkg::BASE_ADDR[31:8]; // RL1
  assign offset = paddr[7:0];
  assign hit_id = in_window && offset == special_function_pkg::ID_OFFSET; // RL1
  assign hit_ext = in_window && offset == special_function_pkg::EXTENSION_OFFSET; // RL1
  assign hit_cause = in_window && offset == special_function_pkg::CAUSE_OFFSET;
  assign hit_reserved = in_window && (offset == special_function_pkg::RESERVED_A_OFFSET ||
    offset == special_function_pkg::RESERVED_B_OFFSET); // RL16
  assign hit_protect = in_window && offset == special_function_pkg::PROTECT_OFFSET;
  assign mapped = hit_id || hit_ext || hit_cause || hit_reserved || hit_protect;
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  // Key and protect bit lanes must both be written
  assign key_ok = pwdata[31:special_function_pkg::KEY_LSB] == special_function_pkg::PROTECT_KEY; // RL11
  assign protect_write = access_phase && pwrite && hit_protect && key_ok && pstrb[3] && pstrb[2] &&
    pstrb[0]; // RL11

  // Protect mode state
  logic protect_reg;
  logic protect_next;

  always_comb begin
    protect_next = protect_reg;
    if (protect_write) begin
      protect_next = pwdata[special_function_pkg::PROTECT_BIT]; // RL13
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      protect_reg <= special_function_pkg::PROTECT_RESET; // RL16
    end else begin
      protect_reg <= protect_next;
    end
  end

  assign interrupt_ctrl_protect_enable = protect_reg; // RL13

  // Reset cause capture
  logic wd_request;
  logic wd_pending_reg;
  logic wd_pending_next;
  logic in_reset_reg;
  logic in_reset_next;
  logic [7:0] cause_reg;
  logic [7:0] cause_next;
  logic reset_exit;

  assign wd_request = watchdog_overflow && watchdog_reset_enable; // RL14
  assign watchdog_internal_reset = wd_request; // RL14
  assign reset_exit = rst_b && in_reset_reg;

  // Pending flag lives across the reset it causes; a new request wins over the clear
  always_comb begin
    wd_pending_next = wd_pending_reg;
    in_reset_next = !rst_b;
    cause_next = cause_reg;
    // Taken on every reset cycle, so a pin that settles late through the synchroniser still counts
    if (!rst_b) begin
      cause_next = (wd_pending_reg && !ext_pin_low) ? special_function_pkg::CAUSE_WATCHDOG :
        special_function_pkg::CAUSE_EXTERNAL; // RL10
    end
    if (reset_exit) begin
      wd_pending_next = 1'b0;
    end
    if (wd_request) begin
      wd_pending_next = 1'b1; // RL14
    end
  end

  // Deliberately outside rst_b: the cause must survive the reset it reports
  always_ff @(posedge clk) begin
    wd_pending_reg <= wd_pending_next;
    in_reset_reg <= in_reset_next;
    cause_reg <= cause_next;
  end

  // Read data registered in setup, so zero wait states
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (setup_phase && !pwrite) begin
      rdata_next = 32'h00000000;
      if (hit_id) begin
        rdata_next = ID_WORD; // RL1
      end else if (hit_ext) begin
        rdata_next = EXTENSION_WORD; // RL9
      end else if (hit_cause) begin
        rdata_next = {24'h000000, cause_reg}; // RL10
      end else if (hit_protect) begin
        rdata_next[special_function_pkg::PROTECT_BIT] = protect_reg; // RL12
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = 1'b1;
  // Writes to read-only words are accepted silently
  assign pslverr = access_phase && !mapped; // RL15

  // Assertions
  property read_of(logic hit);
    @(posedge clk) disable iff (!rst_b)
      setup_phase && !pwrite && hit ##1 access_phase;
  endproperty

  id_read_value_a: assert property (@(posedge clk) disable iff (!rst_b) // RL1
      (setup_phase && !pwrite && hit_id) ##1 access_phase |-> prdata == ID_WORD && !pslverr)
    else $error("identification read returned wrong word");

  id_fields_a: assert property (@(posedge clk) disable iff (!rst_b) // RL15
      (setup_phase && !pwrite && hit_id) ##1 access_phase |->
        prdata[7:5] == 3'h2 && prdata[31] == 1'b0 && prdata[4:0] == VERSION)
    else $error("fixed identification bits wrong");

  ext_read_value_a: assert property (@(posedge clk) disable iff (!rst_b) // RL9
      (setup_phase && !pwrite && hit_ext) ##1 access_phase |-> prdata == EXTENSION_WORD)
    else $error("extension read returned wrong word");

  key_reads_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // RL12
      (setup_phase && !pwrite && hit_protect) ##1 access_phase |->
        prdata[31:16] == 16'h0000 && prdata[5] == interrupt_ctrl_protect_enable)
    else $error("protect key field read back nonzero");

  bad_key_ignored_a: assert property (@(posedge clk) disable iff (!rst_b) // RL11
      access_phase && pwrite && hit_protect && pwdata[31:16] != special_function_pkg::PROTECT_KEY |=>
        $stable(interrupt_ctrl_protect_enable))
    else $error("write with wrong key changed protect mode");

  good_key_taken_a: assert property (@(posedge clk) disable iff (!rst_b) // RL13
      access_phase && pwrite && hit_protect && pwdata[31:16] == special_function_pkg::PROTECT_KEY && pstrb == 4'hF |=>
        interrupt_ctrl_protect_enable == $past(pwdata[5]))
    else $error("keyed write did not set protect mode");

  protect_reset_a: assert property (@(posedge clk) // RL16
      !rst_b |=> !interrupt_ctrl_protect_enable)
    else $error("protect mode not normal after reset");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // RL16
      (setup_phase && !pwrite && hit_reserved) ##1 access_phase |-> prdata == 32'h00000000 && !pslverr)
    else $error("reserved offset read nonzero");

  cause_code_a: assert property (@(posedge clk) disable iff (!rst_b) // RL10
      (setup_phase && !pwrite && hit_cause) ##1 access_phase |->
        prdata == {24'h000000, special_function_pkg::CAUSE_EXTERNAL} ||
        prdata == {24'h000000, special_function_pkg::CAUSE_WATCHDOG})
    else $error("reset cause holds an undefined code");

  wd_cause_a: assert property (@(posedge clk) // RL10
      !rst_b && wd_pending_reg && !ext_pin_low |=> cause_reg == special_function_pkg::CAUSE_WATCHDOG)
    else $error("watchdog reset not reported");

  wd_request_a: assert property (@(posedge clk) // RL14
      watchdog_overflow && !watchdog_reset_enable |-> !watchdog_internal_reset)
    else $error("watchdog reset without enable");

  wd_pending_a: assert property (@(posedge clk) // RL14
      wd_request |=> wd_pending_reg)
    else $error("watchdog request not remembered");

  ro_write_a: assert property (@(posedge clk) disable iff (!rst_b) // RL15
      access_phase && pwrite && (hit_id || hit_ext || hit_cause) |=>
        $stable(cause_reg) && $stable(interrupt_ctrl_protect_enable))
    else $error("write to read-only register had an effect");

  ext_cause_a: assert property (@(posedge clk) // RL10
      !rst_b && ext_pin_low |=>
        cause_reg == special_function_pkg::CAUSE_EXTERNAL)
    else $error("pin reset not reported");

  pending_clear_a: assert property (@(posedge clk) // RL14
      reset_exit && !wd_request |=>
        !wd_pending_reg)
    else $error("watchdog request outlived its reset");

  pending_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RL14
      rst_b && !wd_request && !reset_exit |=>
        $stable(wd_pending_reg))
    else $error("watchdog request flag changed without cause");

  cause_hold_a: assert property (@(posedge clk) // RL15
      rst_b |=>
        $stable(cause_reg))
    else $error("reset cause changed outside reset");

  cause_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RL10
      (setup_phase && !pwrite && hit_cause) ##1 access_phase |->
        prdata == {24'h000000, cause_reg})
    else $error("reset cause read returned wrong word");

  protect_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RL11
      !protect_write |=>
        $stable(interrupt_ctrl_protect_enable))
    else $error("protect mode changed without a keyed write");

  strobe_needed_a: assert property (@(posedge clk) disable iff (!rst_b) // RL11
      access_phase && pwrite && hit_protect && !(pstrb[3] && pstrb[2] && pstrb[0]) |=>
        $stable(interrupt_ctrl_protect_enable))
    else $error("partial write changed protect mode");

  read_stands_a: assert property (@(posedge clk) disable iff (!rst_b) // RL1
      !(setup_phase && !pwrite) |=>
        $stable(prdata))
    else $error("read data changed outside a read setup");

  reserved_write_a: assert property (@(posedge clk) disable iff (!rst_b) // RL16
      access_phase && pwrite && hit_reserved |=>
        $stable(cause_reg) && $stable(interrupt_ctrl_protect_enable))
    else $error("write to reserved offset had an effect");

  reset_read_zero_a: assert property (@(posedge clk) // RL16
      !rst_b |=>
        prdata == 32'h00000000)
    else $error("read data not cleared by reset");

  unmapped_err_a: assert property (@(posedge clk) // RL1
      access_phase && paddr[31:8] != special_function_pkg::BASE_ADDR[31:8] |->
        pslverr)
    else $error("access outside the window not refused");

  err_only_access_a: assert property (@(posedge clk) // RL1
      !access_phase |->
        !pslverr)
    else $error("error response outside an access");

  mapped_write_ok_a: assert property (@(posedge clk) // RL15
      access_phase && pwrite && (hit_id || hit_ext || hit_cause) |->
        !pslverr)
    else $error("write to read-only register refused");

  id_read_c: cover property (read_of(hit_id));
  protect_set_c: cover property (@(posedge clk) disable iff (!rst_b) protect_write && pwdata[5]);
  bad_key_c: cover property (@(posedge clk) disable iff (!rst_b)
    access_phase && pwrite && hit_protect && !key_ok);
  wd_cause_c: cover property (@(posedge clk) cause_reg == special_function_pkg::CAUSE_WATCHDOG);
  ext_cause_c: cover property (@(posedge clk) rst_b && cause_reg == special_function_pkg::CAUSE_EXTERNAL);

endmodule // special_function_registers

// ### tb/special_function_registers_bench.sv
`timescale 1ns/100ps
module special_function_registers_bench;
  localparam logic [4:0] VER = 5'h1F;
  localparam logic [3:0] PSIZE = 4'h3;
  localparam logic [3:0] VSIZE = 4'h1;
  localparam logic [2:0] MTYPE = 3'h4;
  // Arbitrary values
  localparam logic [7:0] FAM = 8'h12;
  localparam logic [31:0] EXT_WORD = 32'h00000000;
  localparam logic [31:0] ID_EXP = {1'b0, MTYPE, FAM, VSIZE, 4'h0, PSIZE, 3'h2, VER};
  localparam logic [31:0] BASE = special_function_pkg::BASE_ADDR;
  localparam logic [31:0] KEYED = {special_function_pkg::PROTECT_KEY, 16'h0020};

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_pin_b = 1'b1;
  logic wd_ovf = 1'b0;
  logic wd_en = 1'b0;
  logic wd_rst;
  logic protect;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;

  special_function_registers #(.VERSION(VER), .PROG_SIZE(PSIZE), .DATA_NV_SIZE(4'h0), .VOLATILE_SIZE(VSIZE),
    .FAMILY_CODE(FAM), .MEM_TYPE(MTYPE), .EXTENSION_WORD(EXT_WORD)) DUT (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin_b(ext_pin_b), .watchdog_overflow(wd_ovf), .watchdog_reset_enable(wd_en),
    .watchdog_internal_reset(wd_rst), .interrupt_ctrl_protect_enable(protect));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One APB transfer; the wait for pready has no limit of its own, only the bench timeout
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data, input logic [3:0] strb);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    pstrb <= strb;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    check("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pin falls with reset when pin_low is set; the cause is taken on every reset cycle, after the synchroniser settles
  task automatic do_reset(input logic pin_low);
    ext_pin_b <= !pin_low;
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    ext_pin_b <= 1'b1;
    @(posedge clk);
  endtask

  task automatic test_map();
    apb(1'b0, BASE, 32'h0, 4'hF);
    check("id word", rd, ID_EXP);
    check("id err", {31'h0, err}, 32'h0);
    apb(1'b0, BASE + 32'h4, 32'h0, 4'hF);
    check("extension", rd, EXT_WORD);
    apb(1'b0, BASE + 32'h10, 32'h0, 4'hF);
    check("reserved 10", rd, 32'h0);
    apb(1'b0, BASE + 32'h14, 32'h0, 4'hF);
    check("reserved 14", rd, 32'h0);
    apb(1'b0, BASE + 32'h18, 32'h0, 4'hF);
    check("protect reset", rd, 32'h0);
    apb(1'b0, BASE + 32'hC, 32'h0, 4'hF);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b0, 32'hFFF10000, 32'h0, 4'hF);
    check("other base err", {31'h0, err}, 32'h1);
    $display("test map done");
  endtask

  task automatic test_readonly();
    apb(1'b0, BASE + 32'h8, 32'h0, 4'hF);
    check("cause after pin reset", rd, 32'h0000006C);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, BASE + 32'(i * 4), 32'hFFFFFFFF, 4'hF);
    end
    apb(1'b0, BASE, 32'h0, 4'hF);
    check("id after write", rd, ID_EXP);
    apb(1'b0, BASE + 32'h4, 32'h0, 4'hF);
    check("ext after write", rd, EXT_WORD);
    apb(1'b0, BASE + 32'h8, 32'h0, 4'hF);
    check("cause after write", rd, 32'h0000006C);
    apb(1'b0, BASE + 32'h10, 32'h0, 4'hF);
    check("reserved after write", rd, 32'h0);
    $display("test readonly done");
  endtask

  task automatic test_protect();
    apb(1'b1, BASE + 32'h18, {16'h27A9, 16'h0020}, 4'hF);
    @(posedge clk);
    check("bad key out", {31'h0, protect}, 32'h0);
    apb(1'b1, BASE + 32'h18, KEYED, 4'h0);
    @(posedge clk);
    check("no strobe out", {31'h0, protect}, 32'h0);
    apb(1'b1, BASE + 32'h18, KEYED, 4'hF);
    @(posedge clk);
    check("good key out", {31'h0, protect}, 32'h1);
    apb(1'b0, BASE + 32'h18, 32'h0, 4'hF);
    check("readback", rd, 32'h00000020);
    apb(1'b1, BASE + 32'h18, 32'h0000FFDF, 4'hF);
    @(posedge clk);
    check("keyless keeps", {31'h0, protect}, 32'h1);
    apb(1'b1, BASE + 32'h18, {special_function_pkg::PROTECT_KEY, 16'h0000}, 4'hF);
    @(posedge clk);
    check("cleared out", {31'h0, protect}, 32'h0);
    $display("test protect done");
  endtask

  task automatic wd_pulse(input logic en);
    wd_en <= en;
    @(posedge clk);
    wd_ovf <= 1'b1;
    @(posedge clk);
    check("wd request", {31'h0, wd_rst}, {31'h0, en});
    wd_ovf <= 1'b0;
    @(posedge clk);
    wd_en <= 1'b0;
  endtask

  task automatic test_cause();
    apb(1'b1, BASE + 32'h18, KEYED, 4'hF);
    wd_pulse(1'b0);
    do_reset(1'b0);
    check("protect after reset", {31'h0, protect}, 32'h0);
    apb(1'b0, BASE + 32'h8, 32'h0, 4'hF);
    check("cause no request", rd, 32'h0000006C);
    wd_pulse(1'b1);
    do_reset(1'b0);
    apb(1'b0, BASE + 32'h8, 32'h0, 4'hF);
    check("cause watchdog", rd, 32'h00000053);
    do_reset(1'b1);
    apb(1'b0, BASE + 32'h8, 32'h0, 4'hF);
    check("cause pin", rd, 32'h0000006C);
    $display("test cause done");
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      $display("Error timeout expected done seen hang");
      end_sim();
    end
  end

  initial begin
    do_reset(1'b1);
    test_map();
    test_readonly();
    test_protect();
    test_cause();
    end_sim();
  end
endmodule // special_function_registers_bench
